// *** common/cgip_regs.svh ***
// Purpose: register offsets, field positions, resets and timing figures
// Assumes: byte-wide registers on page 0 of the codec control bus
// Notes:   timing figures are typical values, the clock period is in ns
`ifndef CGIP_REGS_SVH
`define CGIP_REGS_SVH

`define CGIP_ADDR_BTN_CLR   7'h0E
`define CGIP_ADDR_FLAGS     7'h60
`define CGIP_ADDR_PIN1      7'h62
`define CGIP_ADDR_PIN2      7'h63

`define CGIP_PIN1_RST       8'h00
`define CGIP_PIN2_RST       8'h00

`define CGIP_P1_GPO_BIT     0
`define CGIP_P1_GPI_BIT     1
`define CGIP_P1_STYLE_BIT   2
`define CGIP_P1_MUX_BIT     3
`define CGIP_P1_FUNC_LSB    4

`define CGIP_P2_RSVD_BIT    0
`define CGIP_P2_STYLE_BIT   1
`define CGIP_P2_GPI_BIT     2
`define CGIP_P2_GPO_BIT     3
`define CGIP_P2_FUNC_LSB    4

`define CGIP_CLK_NS         5
`define CGIP_PULSE_US       2000
`define CGIP_HSD_US         1750
`define CGIP_US_NS          1000

`endif

// *** common/cgip_pkg.sv ***
// Purpose: types shared by the multifunction pin block
// Assumes: nothing
// Notes:   function codes of the second pin, pulse generator states
package cgip_pkg;

	typedef enum logic [3:0]
	{
		CGIP_F_OFF   = 4'h0,
		CGIP_F_RSVD  = 4'h1,
		CGIP_F_HSD   = 4'h2,
		CGIP_F_GPI   = 4'h3,
		CGIP_F_GPO   = 4'h4,
		CGIP_F_DMIC0 = 4'h5,
		CGIP_F_DMIC1 = 4'h6,
		CGIP_F_DMIC2 = 4'h7,
		CGIP_F_BCLK  = 4'h8,
		CGIP_F_HB    = 4'h9,
		CGIP_F_ALL   = 4'hA,
		CGIP_F_HA    = 4'hB,
		CGIP_F_HBS   = 4'hC,
		CGIP_F_SHORT = 4'hD,
		CGIP_F_AGC   = 4'hE,
		CGIP_F_BTN   = 4'hF
	} cgip_func_type;

	typedef enum logic [2:0]
	{
		CGIP_IDLE = 3'h1,
		CGIP_HIGH = 3'h2,
		CGIP_LOW  = 3'h4
	} cgip_pulse_type;

endpackage

// *** src/cgip_sync.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to i_clock
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
module cgip_sync
#(
	parameter int WIDTH = 2
)
(
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule

// *** src/cgip_pulse.sv ***
// Purpose: interrupt pulse generator for one multifunction pin
// Assumes: i_len at least 1 and steady while a pulse runs
// Notes:   single pulse, or high/low train until the flags are read
`timescale 1ns/10ps
module cgip_pulse
	import cgip_pkg::*;
#(
	parameter int CNT_W = 20
)
(
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_event,
	input  wire logic             i_repeat,
	input  wire logic             i_flags_read,
	input  wire logic [CNT_W-1:0] i_len,
	output logic                  o_pulse
);
	cgip_pulse_type   state_r;
	cgip_pulse_type   state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             pend_r;
	logic             pend_nxt;
	logic [CNT_W:0]   hi_cnt_r;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		// a new event wins over the flags read
		pend_nxt  = (pend_r & ~i_flags_read) | (i_event & i_repeat);
		unique case (state_r)
			CGIP_IDLE:
			begin
				if (i_event)
				begin
					state_nxt = CGIP_HIGH;
					cnt_nxt   = i_len - 1'b1;
				end
			end
			CGIP_HIGH:
			begin
				if (cnt_r == '0)
				begin
					if (i_repeat && pend_r)
					begin
						state_nxt = CGIP_LOW;
						cnt_nxt   = i_len - 1'b1;
					end
					else
					begin
						state_nxt = CGIP_IDLE;
					end
				end
				else
				begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			CGIP_LOW:
			begin
				if (cnt_r == '0)
				begin
					if (pend_r)
					begin
						state_nxt = CGIP_HIGH;
						cnt_nxt   = i_len - 1'b1;
					end
					else
					begin
						state_nxt = CGIP_IDLE;
					end
				end
				else
				begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default:
			begin
				state_nxt = CGIP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= CGIP_IDLE;
			cnt_r   <= '0;
			pend_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			pend_r  <= pend_nxt;
		end
	end

	assign o_pulse = (state_r == CGIP_HIGH);

	// length of the current high phase, for checking only
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			hi_cnt_r <= '0;
		else
			hi_cnt_r <= o_pulse ? hi_cnt_r + 1'b1 : '0;
	end

	property p_len;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(o_pulse) |-> (hi_cnt_r == (CNT_W+1)'(i_len));
	endproperty
	a_len: assert property (p_len)
		else $error("interrupt pulse length differs from programmed count");

	property p_single;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_r == CGIP_HIGH && cnt_r == '0 && !i_repeat)
			|=> (state_r == CGIP_IDLE) ##1 (o_pulse == $past(i_event));
	endproperty
	a_single: assert property (p_single)
		else $error("single pulse mode produced a second pulse");

	property p_stop;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_r == CGIP_LOW && cnt_r == '0 && !pend_r)
			|=> (state_r == CGIP_IDLE);
	endproperty
	a_stop: assert property (p_stop)
		else $error("pulse train continued after flags were read");

	property p_more;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_r == CGIP_HIGH && cnt_r == '0 && i_repeat && pend_r)
			|=> (state_r == CGIP_LOW);
	endproperty
	a_more: assert property (p_more)
		else $error("pulse train stopped before flags were read");
endmodule

// *** src/cgip_top.sv ***
// Purpose: two codec multifunction pins with their control registers
// Assumes: register port and event inputs are on i_clock
// Notes:   pin levels pass a two-flop synchroniser before use
// Notes on behaviour
// - first pin, style 0: each event gives one high pulse of 2 ms
// - first pin, style 1: pulses repeat until the flags register is read
// - first pin readback bit D1 shows the level on the pin
// - first pin as output drives the level held in bit D0
// - second pin code 0000 disables it; code 0001 is reserved
// - code 0010 outputs headset detect interrupt, 1.75 ms high pulse
// - code 0011 makes a general input, 0100 a general output
// - codes 0101-0111 take microphone data on both clock edges
// - code 1000 makes the pin the bit clock, direction set elsewhere
// - code 1001 outputs headset OR button interrupt
// - code 1010 outputs headset, button, short or noise interrupt
// - code 1011 outputs headset OR noise interrupt
// - code 1100 outputs headset, button or short interrupt
// - code 1101 outputs only the short circuit interrupt
// - noise and button interrupts each have their own code
// - second pin as output drives the level held in bit D3
// - second pin readback bit D2 shows the level on the pin
// - second pin bit D1 picks single pulse or pulse train
// - noise flag is set while channel power is below its threshold
// - button flag is sticky, cleared by reading register 14
`timescale 1ns/10ps
`include "cgip_regs.svh"
module cgip_top
#(
	parameter int CNT_W     = 20,
	parameter int PWR_W     = 16,
	parameter int PULSE_CYC = `CGIP_PULSE_US * `CGIP_US_NS / `CGIP_CLK_NS,
	parameter int HSD_CYC   = `CGIP_HSD_US * `CGIP_US_NS / `CGIP_CLK_NS
)
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic [6:0]        i_reg_addr,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	input  wire logic [7:0]        i_reg_wdata,
	output logic      [7:0]        o_reg_rdata,
	input  wire logic              i_headset_evt,
	input  wire logic              i_button_evt,
	input  wire logic              i_short_evt,
	input  wire logic [PWR_W-1:0]  i_agc_pwr_l,
	input  wire logic [PWR_W-1:0]  i_agc_pwr_r,
	input  wire logic [PWR_W-1:0]  i_agc_thr_l,
	input  wire logic [PWR_W-1:0]  i_agc_thr_r,
	output logic                   o_agc_noise_l,
	output logic                   o_agc_noise_r,
	output logic                   o_button_sticky,
	input  wire logic              i_pin1_in,
	output logic                   o_pin1_out,
	output logic                   o_pin1_oe,
	output logic      [3:0]        o_pin1_func,
	output logic                   o_pin1_clkmux,
	input  wire logic              i_pin1_gpo_sel,
	input  wire logic              i_pin1_int_sel,
	input  wire logic              i_pin1_event,
	input  wire logic              i_pin2_in,
	output logic                   o_pin2_out,
	output logic                   o_pin2_oe,
	output cgip_pkg::cgip_func_type o_pin2_func,
	input  wire logic              i_dmic_clk,
	output logic                   o_dmic_data,
	output logic                   o_dmic_valid,
	output logic                   o_dmic_rise,
	input  wire logic              i_bclk_dir_out,
	input  wire logic              i_bclk_out,
	output logic                   o_bclk_in
);
	import cgip_pkg::*;

	// register state
	logic [3:0]    p1_func_r;
	logic [3:0]    p1_func_nxt;
	logic          p1_mux_r;
	logic          p1_mux_nxt;
	logic          p1_style_r;
	logic          p1_style_nxt;
	logic          p1_gpo_r;
	logic          p1_gpo_nxt;
	cgip_func_type p2_func_r;
	cgip_func_type p2_func_nxt;
	logic          p2_gpo_r;
	logic          p2_gpo_nxt;
	logic          p2_style_r;
	logic          p2_style_nxt;
	logic [7:0]    rdata_r;
	logic [7:0]    rdata_nxt;

	// status and event state
	logic          noise_l_r;
	logic          noise_r_r;
	logic          noise_prev_r;
	logic          btn_sticky_r;
	logic          btn_sticky_nxt;

	// pin state
	logic          p1_out_r;
	logic          p1_out_nxt;
	logic          p1_oe_r;
	logic          p1_oe_nxt;
	logic          p2_out_r;
	logic          p2_out_nxt;
	logic          p2_oe_r;
	logic          p2_oe_nxt;
	logic          dclk_prev_r;
	logic          dmic_data_r;
	logic          dmic_data_nxt;
	logic          dmic_valid_r;
	logic          dmic_valid_nxt;
	logic          dmic_rise_r;
	logic          dmic_rise_nxt;

	logic [1:0]    pin_s;
	logic          rd_flags;
	logic          rd_btn;
	logic          agc_evt;
	logic          p2_evt;
	logic          p2_is_int;
	logic          pulse1;
	logic          pulse2;
	logic [CNT_W-1:0] p2_len;

	cgip_sync #(.WIDTH(2)) u_sync
	(
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({i_pin2_in, i_pin1_in}),
		.o_sync  (pin_s)
	);

	assign rd_flags = i_reg_rd && (i_reg_addr == `CGIP_ADDR_FLAGS);
	assign rd_btn   = i_reg_rd && (i_reg_addr == `CGIP_ADDR_BTN_CLR);

	// register writes and registered read data
	always_comb
	begin
		p1_func_nxt  = p1_func_r;
		p1_mux_nxt   = p1_mux_r;
		p1_style_nxt = p1_style_r;
		p1_gpo_nxt   = p1_gpo_r;
		p2_func_nxt  = p2_func_r;
		p2_gpo_nxt   = p2_gpo_r;
		p2_style_nxt = p2_style_r;
		rdata_nxt    = rdata_r;
		if (i_reg_wr && i_reg_addr == `CGIP_ADDR_PIN1)
		begin
			p1_func_nxt  = i_reg_wdata[7:`CGIP_P1_FUNC_LSB];
			p1_mux_nxt   = i_reg_wdata[`CGIP_P1_MUX_BIT];
			p1_style_nxt = i_reg_wdata[`CGIP_P1_STYLE_BIT];
			p1_gpo_nxt   = i_reg_wdata[`CGIP_P1_GPO_BIT];
		end
		if (i_reg_wr && i_reg_addr == `CGIP_ADDR_PIN2)
		begin
			p2_func_nxt  = cgip_func_type'(
				i_reg_wdata[7:`CGIP_P2_FUNC_LSB]);
			p2_gpo_nxt   = i_reg_wdata[`CGIP_P2_GPO_BIT];
			p2_style_nxt = i_reg_wdata[`CGIP_P2_STYLE_BIT];
		end
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				`CGIP_ADDR_PIN1:
				begin
					rdata_nxt = {p1_func_r, p1_mux_r, p1_style_r,
						pin_s[0], p1_gpo_r};
				end
				`CGIP_ADDR_PIN2:
				begin
					rdata_nxt = {p2_func_r, p2_gpo_r, pin_s[1],
						p2_style_r, 1'b0};
				end
				default:
				begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			p1_func_r  <= 4'(`CGIP_PIN1_RST >> `CGIP_P1_FUNC_LSB);
			p1_mux_r   <= 1'b0;
			p1_style_r <= 1'b0;
			p1_gpo_r   <= 1'b0;
			p2_func_r  <= CGIP_F_OFF;
			p2_gpo_r   <= 1'b0;
			p2_style_r <= 1'b0;
			rdata_r    <= 8'h00;
		end
		else
		begin
			p1_func_r  <= p1_func_nxt;
			p1_mux_r   <= p1_mux_nxt;
			p1_style_r <= p1_style_nxt;
			p1_gpo_r   <= p1_gpo_nxt;
			p2_func_r  <= p2_func_nxt;
			p2_gpo_r   <= p2_gpo_nxt;
			p2_style_r <= p2_style_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// status flags; a new button event wins over the clearing read
	always_comb
	begin
		btn_sticky_nxt = (btn_sticky_r & ~rd_btn) | i_button_evt;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			noise_l_r    <= 1'b0;
			noise_r_r    <= 1'b0;
			noise_prev_r <= 1'b0;
			btn_sticky_r <= 1'b0;
		end
		else
		begin
			noise_l_r    <= (i_agc_pwr_l < i_agc_thr_l);
			noise_r_r    <= (i_agc_pwr_r < i_agc_thr_r);
			noise_prev_r <= noise_l_r | noise_r_r;
			btn_sticky_r <= btn_sticky_nxt;
		end
	end

	assign agc_evt = (noise_l_r | noise_r_r) & ~noise_prev_r;

	// interrupt source selection for the second pin
	always_comb
	begin
		p2_is_int = 1'b1;
		p2_evt    = 1'b0;
		unique case (p2_func_r)
			CGIP_F_HSD:   p2_evt = i_headset_evt;
			CGIP_F_HB:    p2_evt = i_headset_evt | i_button_evt;
			CGIP_F_ALL:   p2_evt = i_headset_evt | i_button_evt |
				i_short_evt | agc_evt;
			CGIP_F_HA:    p2_evt = i_headset_evt | agc_evt;
			CGIP_F_HBS:   p2_evt = i_headset_evt | i_button_evt |
				i_short_evt;
			CGIP_F_SHORT: p2_evt = i_short_evt;
			CGIP_F_AGC:   p2_evt = agc_evt;
			CGIP_F_BTN:   p2_evt = i_button_evt;
			default:      p2_is_int = 1'b0;
		endcase
	end

	assign p2_len = (p2_func_r == CGIP_F_HSD) ? CNT_W'(HSD_CYC) :
		CNT_W'(PULSE_CYC);

	cgip_pulse #(.CNT_W(CNT_W)) u_pulse1
	(
		.i_clock      (i_clock),
		.i_rst_n      (i_rst_n),
		.i_event      (i_pin1_event),
		.i_repeat     (p1_style_r),
		.i_flags_read (rd_flags),
		.i_len        (CNT_W'(PULSE_CYC)),
		.o_pulse      (pulse1)
	);

	cgip_pulse #(.CNT_W(CNT_W)) u_pulse2
	(
		.i_clock      (i_clock),
		.i_rst_n      (i_rst_n),
		.i_event      (p2_evt),
		.i_repeat     (p2_style_r),
		.i_flags_read (rd_flags),
		.i_len        (p2_len),
		.o_pulse      (pulse2)
	);

	// pin drive and microphone sampling
	always_comb
	begin
		p1_out_nxt     = 1'b0;
		p1_oe_nxt      = 1'b0;
		p2_out_nxt     = 1'b0;
		p2_oe_nxt      = 1'b0;
		dmic_data_nxt  = dmic_data_r;
		dmic_valid_nxt = 1'b0;
		dmic_rise_nxt  = dmic_rise_r;
		if (i_pin1_gpo_sel)
		begin
			p1_out_nxt = p1_gpo_r;
			p1_oe_nxt  = 1'b1;
		end
		else if (i_pin1_int_sel)
		begin
			p1_out_nxt = pulse1;
			p1_oe_nxt  = 1'b1;
		end
		if (p2_func_r == CGIP_F_GPO)
		begin
			p2_out_nxt = p2_gpo_r;
			p2_oe_nxt  = 1'b1;
		end
		else if (p2_func_r == CGIP_F_BCLK)
		begin
			p2_out_nxt = i_bclk_out;
			p2_oe_nxt  = i_bclk_dir_out;
		end
		else if (p2_is_int)
		begin
			p2_out_nxt = pulse2;
			p2_oe_nxt  = 1'b1;
		end
		if ((p2_func_r == CGIP_F_DMIC0 || p2_func_r == CGIP_F_DMIC1 ||
			p2_func_r == CGIP_F_DMIC2) && (i_dmic_clk != dclk_prev_r))
		begin
			dmic_data_nxt  = pin_s[1];
			dmic_valid_nxt = 1'b1;
			dmic_rise_nxt  = i_dmic_clk;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			p1_out_r     <= 1'b0;
			p1_oe_r      <= 1'b0;
			p2_out_r     <= 1'b0;
			p2_oe_r      <= 1'b0;
			dclk_prev_r  <= 1'b0;
			dmic_data_r  <= 1'b0;
			dmic_valid_r <= 1'b0;
			dmic_rise_r  <= 1'b0;
		end
		else
		begin
			p1_out_r     <= p1_out_nxt;
			p1_oe_r      <= p1_oe_nxt;
			p2_out_r     <= p2_out_nxt;
			p2_oe_r      <= p2_oe_nxt;
			dclk_prev_r  <= i_dmic_clk;
			dmic_data_r  <= dmic_data_nxt;
			dmic_valid_r <= dmic_valid_nxt;
			dmic_rise_r  <= dmic_rise_nxt;
		end
	end

	assign o_reg_rdata     = rdata_r;
	assign o_agc_noise_l   = noise_l_r;
	assign o_agc_noise_r   = noise_r_r;
	assign o_button_sticky = btn_sticky_r;
	assign o_pin1_out      = p1_out_r;
	assign o_pin1_oe       = p1_oe_r;
	assign o_pin1_func     = p1_func_r;
	assign o_pin1_clkmux   = p1_mux_r;
	assign o_pin2_out      = p2_out_r;
	assign o_pin2_oe       = p2_oe_r;
	assign o_pin2_func     = p2_func_r;
	assign o_dmic_data     = dmic_data_r;
	assign o_dmic_valid    = dmic_valid_r;
	assign o_dmic_rise     = dmic_rise_r;
	assign o_bclk_in       = pin_s[1];

	property p_off;
		@(posedge i_clock) disable iff (!i_rst_n)
		(p2_func_r == CGIP_F_OFF || p2_func_r == CGIP_F_RSVD)
			|=> !o_pin2_oe;
	endproperty
	a_off: assert property (p_off)
		else $error("second pin driven while disabled");

	property p_gpo2;
		@(posedge i_clock) disable iff (!i_rst_n)
		(p2_func_r == CGIP_F_GPO)
			|=> o_pin2_oe && (o_pin2_out == $past(p2_gpo_r));
	endproperty
	a_gpo2: assert property (p_gpo2)
		else $error("second pin output level wrong");

	property p_gpo1;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_pin1_gpo_sel |=> o_pin1_oe && (o_pin1_out == $past(p1_gpo_r));
	endproperty
	a_gpo1: assert property (p_gpo1)
		else $error("first pin output level wrong");

	property p_rd1;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_reg_rd && i_reg_addr == `CGIP_ADDR_PIN1)
			|=> (o_reg_rdata[`CGIP_P1_GPI_BIT] == $past(pin_s[0]));
	endproperty
	a_rd1: assert property (p_rd1)
		else $error("first pin readback wrong");

	property p_rd2;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_reg_rd && i_reg_addr == `CGIP_ADDR_PIN2)
			|=> (o_reg_rdata[`CGIP_P2_GPI_BIT] == $past(pin_s[1]))
			&& !o_reg_rdata[`CGIP_P2_RSVD_BIT];
	endproperty
	a_rd2: assert property (p_rd2)
		else $error("second pin readback wrong");

	property p_btn;
		@(posedge i_clock) disable iff (!i_rst_n)
		(o_button_sticky && !rd_btn && !i_button_evt)
			|=> o_button_sticky;
	endproperty
	a_btn: assert property (p_btn)
		else $error("button flag lost without a clearing read");

	property p_noise;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_agc_pwr_l >= i_agc_thr_l) |=> !o_agc_noise_l;
	endproperty
	a_noise: assert property (p_noise)
		else $error("noise flag set above threshold");
endmodule

// *** dv/cgip_host_model.sv ***
// Purpose: host side of one multifunction pin, wire level, pulse widths
// Assumes: no pull on the pin, an undriven pin takes the bench level
// Notes:   widths counted in i_clock cycles of high wire level, driven or not
`timescale 1ns/10ps
module cgip_host_model
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_out,
	input  wire logic i_oe,
	input  wire logic i_ext,
	output logic      o_level,
	output int        o_len,
	output int        o_falls
);
	int run;

	// device drives while enabled, else the outside level holds the wire
	assign o_level = i_oe ? i_out : i_ext;

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			run <= 0;
			o_len <= 0;
			o_falls <= 0;
		end
		else if (o_level)
			run <= run + 1;
		else if (run != 0)
		begin
			o_len <= run;
			o_falls <= o_falls + 1;
			run <= 0;
		end
	end
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench of the two multifunction pins
// Assumes: short pulse lengths set through parameters
// Notes:   host models resolve the pin wires
`timescale 1ns/10ps
module tb;
	import cgip_pkg::*;
	localparam int PL = 8;
	localparam int HL = 6;
	logic        clk, rst_n, wr, rd, hs, bt, sh, nl, nr, bs;
	logic [6:0]  addr;
	logic [7:0]  wd, rdat;
	logic [15:0] pwr_l, pwr_r, thr_l, thr_r;
	logic        p1_in, p1_out, p1_oe, p1g, p1i, p1e, e1, e2;
	logic        p2_in, p2_out, p2_oe, mc, md, mv, mr, bdir, bout, bin;
	logic [3:0]  p1f, p2f;
	logic        p1m;
	int          failures, checked;

	cgip_top #(.PULSE_CYC(PL), .HSD_CYC(HL)) u_cgip_top (
		.i_clock(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
		.o_reg_rdata(rdat), .i_headset_evt(hs), .i_button_evt(bt),
		.i_short_evt(sh), .i_agc_pwr_l(pwr_l), .i_agc_pwr_r(pwr_r),
		.i_agc_thr_l(thr_l), .i_agc_thr_r(thr_r), .o_agc_noise_l(nl),
		.o_agc_noise_r(nr), .o_button_sticky(bs), .i_pin1_in(p1_in),
		.o_pin1_out(p1_out), .o_pin1_oe(p1_oe), .o_pin1_func(p1f),
		.o_pin1_clkmux(p1m), .i_pin1_gpo_sel(p1g), .i_pin1_int_sel(p1i),
		.i_pin1_event(p1e), .i_pin2_in(p2_in), .o_pin2_out(p2_out),
		.o_pin2_oe(p2_oe), .o_pin2_func(p2f), .i_dmic_clk(mc),
		.o_dmic_data(md), .o_dmic_valid(mv), .o_dmic_rise(mr),
		.i_bclk_dir_out(bdir), .i_bclk_out(bout), .o_bclk_in(bin));

	cgip_host_model u_host1 (.i_clock(clk), .i_rst_n(rst_n),
		.i_out(p1_out), .i_oe(p1_oe), .i_ext(e1), .o_level(p1_in),
		.o_len(), .o_falls());
	cgip_host_model u_host2 (.i_clock(clk), .i_rst_n(rst_n),
		.i_out(p2_out), .i_oe(p2_oe), .i_ext(e2), .o_level(p2_in),
		.o_len(), .o_falls());

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task wrap_up;
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic logic pin(input int p);
		return p == 2 ? p2_out : p1_out;
	endfunction

	function automatic int falls(input int p);
		return p == 2 ? u_host2.o_falls : u_host1.o_falls;
	endfunction

	task wreg(input logic [6:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask

	task rstb(input logic [6:0] a);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
	endtask

	task rreg(input logic [6:0] a, input logic [7:0] e);
		rstb(a);
		chk(rdat, e);
		tick(1);
	endtask

	// bounded wait for a pin level, a miss ends the run
	task wt(input int p, input logic v);
		int i;
		i = 0;
		while (pin(p) !== v && i < 40)
		begin
			tick(1);
			i++;
		end
		if (pin(p) !== v)
		begin
			chk({7'h0, pin(p)}, {7'h0, v});
			wrap_up();
		end
	endtask

	// 0 headset, 1 button, 2 short, 3 noise on the left channel
	task fire(input int s);
		case (s)
			0: hs = 1'b1;
			1: bt = 1'b1;
			2: sh = 1'b1;
			default: pwr_l = 16'h0000;
		endcase
		tick(1);
		{hs, bt, sh} = 3'b000;
		if (s == 3)
		begin
			tick(1);
			chk({7'h0, nl}, 8'h01);
			pwr_l = 16'hFFFF;
		end
	endtask

	task train(input int p);
		int n;
		for (int k = 0; k < 3; k++)
		begin
			wt(p, 1'b1);
			wt(p, 1'b0);
		end
		rstb(7'h60);
		tick(40);
		n = falls(p);
		tick(40);
		chk(8'(falls(p) - n), 8'h00);
		chk({7'h0, pin(p)}, 8'h00);
	endtask

	task s_regs;
		rreg(7'h63, 8'h00);
		rreg(7'h62, 8'h00);
		rreg(7'h10, 8'h00);
		chk({7'h0, p2_oe}, 8'h00);
		wreg(7'h63, 8'h48);
		tick(2);
		chk({6'h0, p2_oe, p2_out}, 8'h03);
		rreg(7'h63, 8'h4C);
		wreg(7'h63, 8'h40);
		tick(2);
		chk({6'h0, p2_oe, p2_out}, 8'h02);
		wreg(7'h63, 8'h00);
		tick(2);
		chk({7'h0, p2_oe}, 8'h00);
		e2 = 1'b1;
		wreg(7'h63, 8'h30);
		tick(3);
		rreg(7'h63, 8'h34);
		chk({4'h0, p2f}, 8'h03);
		chk({7'h0, p2_oe}, 8'h00);
		p1g = 1'b1;
		wreg(7'h62, 8'h01);
		tick(3);
		chk({6'h0, p1_oe, p1_out}, 8'h03);
		rreg(7'h62, 8'h03);
		wreg(7'h62, 8'hFA);
		tick(3);
		rreg(7'h62, 8'hF8);
		chk({3'h0, p1m, p1f}, 8'h1F);
		p1g = 1'b0;
		e1 = 1'b1;
		tick(3);
		rreg(7'h62, 8'hFA);
		e1 = 1'b0;
	endtask

	task s_pin1;
		int n;
		p1i = 1'b1;
		wreg(7'h62, 8'h00);
		p1e = 1'b1;
		tick(1);
		p1e = 1'b0;
		wt(1, 1'b1);
		wt(1, 1'b0);
		tick(1);
		chk(8'(u_host1.o_len), 8'(PL));
		n = falls(1);
		tick(30);
		chk(8'(falls(1) - n), 8'h00);
		wreg(7'h62, 8'h04);
		p1e = 1'b1;
		tick(1);
		p1e = 1'b0;
		train(1);
	endtask

	task s_codes;
		logic [3:0] cd [8] = '{4'h2, 4'h9, 4'hA, 4'hB,
			4'hC, 4'hD, 4'hE, 4'hF};
		logic [3:0] mk [8] = '{4'h1, 4'h3, 4'hF, 4'h9,
			4'h7, 4'h4, 4'h8, 4'h2};
		logic       hit;
		e2 = 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			wreg(7'h63, {cd[c], 4'h0});
			for (int s = 0; s < 4; s++)
			begin
				fire(s);
				hit = 1'b0;
				repeat (6)
				begin
					tick(1);
					hit = hit | p2_out;
				end
				chk({7'h0, hit}, {7'h0, mk[c][s]});
				if (hit)
				begin
					wt(2, 1'b0);
					tick(1);
					chk(8'(u_host2.o_len), 8'(cd[c] == 4'h2 ? HL : PL));
				end
			end
		end
		wreg(7'h63, 8'hD2);
		fire(2);
		train(2);
	endtask

	task mwait(input logic [7:0] e);
		int i;
		i = 0;
		while (mv !== 1'b1 && i < 4)
		begin
			tick(1);
			i++;
		end
		chk({5'h0, mv, mr, md}, e);
	endtask

	task s_misc;
		for (int c = 5; c < 8; c++)
		begin
			wreg(7'h63, {4'(c), 4'h0});
			e2 = 1'b1;
			tick(3);
			mc = 1'b1;
			mwait(8'h07);
			e2 = 1'b0;
			tick(3);
			mc = 1'b0;
			mwait(8'h04);
		end
		wreg(7'h63, 8'h80);
		bdir = 1'b1;
		bout = 1'b1;
		tick(2);
		chk({6'h0, p2_oe, p2_out}, 8'h03);
		bdir = 1'b0;
		e2 = 1'b1;
		tick(3);
		chk({6'h0, p2_oe, bin}, 8'h01);
		rstb(7'h0E);
		tick(2);
		chk({7'h0, bs}, 8'h00);
		bt = 1'b1;
		tick(1);
		bt = 1'b0;
		tick(6);
		chk({7'h0, bs}, 8'h01);
		rstb(7'h0E);
		tick(2);
		chk({7'h0, bs}, 8'h00);
		pwr_r = 16'h0000;
		tick(2);
		chk({7'h0, nr}, 8'h01);
		pwr_r = 16'hFFFF;
		tick(2);
		chk({7'h0, nr}, 8'h00);
	endtask

	initial
	begin
		failures = 0;
		checked = 0;
		rst_n = 1'b0;
		{wr, rd, hs, bt, sh, p1g, p1i, p1e, e1, e2} = '0;
		{mc, bdir, bout} = '0;
		addr = 7'h00;
		wd = 8'h00;
		{pwr_l, pwr_r} = {16'hFFFF, 16'hFFFF};
		{thr_l, thr_r} = {16'h0100, 16'h0100};
		tick(4);
		rst_n = 1'b1;
		tick(1);
		s_regs;
		s_pin1;
		s_codes;
		s_misc;
		wrap_up();
	end
endmodule
